// ==== logic/ppoc_params.svh ====
`ifndef PPOC_PARAMS_SVH
`define PPOC_PARAMS_SVH

// ==========================================================
// Register map
`define PPOC_ADDR_W 8
`define PPOC_DATA_W 8
`define PPOC_ADDR_PORT_POWER 8'he5
`define PPOC_ADDR_OC_INJECT 8'he6
`define PPOC_RESET_BYTE 8'h00

// ==========================================================
// Field layout: one bit per downstream port
`define PPOC_PORT_LO 1
`define PPOC_PORT_MID 2
`define PPOC_PORT_HI 3
`define PPOC_RSVD_HI_MSB 7
`define PPOC_RSVD_HI_LSB 4
`define PPOC_RSVD_LO 0
`define PPOC_RSVD_HI_ZERO 4'h0

`endif

// ==== logic/ppoc_pkg.sv ====
`include "ppoc_params.svh"

package ppoc_pkg;
  // Register byte and per-port vector types
  typedef logic [`PPOC_DATA_W-1:0] ppoc_byte_t;
  typedef logic [`PPOC_ADDR_W-1:0] ppoc_addr_t;
  typedef logic [`PPOC_PORT_HI:`PPOC_PORT_LO] ppoc_ports_t;
endpackage

// ==== logic/ppoc_port_if.sv ====
`timescale 1ns/1ns
`default_nettype none

// Signals between the register bank and one port slice
interface ppoc_port_if;
  logic host_req;
  logic charge_en;
  logic charge_req;
  logic oc_set;
  logic power_on;
  logic status_bit;
  logic oc_rise;

  modport bank (output host_req, output charge_en, output charge_req, output oc_set,
                input power_on, input status_bit, input oc_rise);
  modport slice (input host_req, input charge_en, input charge_req, input oc_set,
                 output power_on, output status_bit, output oc_rise);
endinterface

`default_nettype wire

// ==== logic/ppoc_port_slice.sv ====
`timescale 1ns/1ns
`default_nettype none

module ppoc_port_slice
  import ppoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link to the register bank
  ppoc_port_if.slice pif
);

  logic power_reg;
  logic power_next;
  logic status_reg;
  logic status_next;
  logic oc_prev_reg;
  logic oc_prev_next;

  // ==========================================================
  // Port power and status
  // Next power, status and over-current edge
  always_comb
  begin
    power_next = (pif.host_req | (pif.charge_en & pif.charge_req)) & ~pif.oc_set;
    status_next = pif.host_req & ~pif.oc_set;
    oc_prev_next = pif.oc_set;
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      power_reg <= 1'b0;
      status_reg <= 1'b0;
      oc_prev_reg <= 1'b0;
    end
    else
    begin
      power_reg <= power_next;
      status_reg <= status_next;
      oc_prev_reg <= oc_prev_next;
    end
  end

  // Outputs towards the bank
  assign pif.power_on = power_reg;
  assign pif.status_bit = status_reg;
  assign pif.oc_rise = pif.oc_set & ~oc_prev_reg; // Hub status change event

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_status_zero;
    (!pif.host_req || pif.oc_set) |=> !pif.status_bit;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("Status set without power");

  property p_status_one;
    (pif.host_req && !pif.oc_set) |=> pif.status_bit;
  endproperty
  a_status_one: assert property (p_status_one) else $error("Status clear while powered");

  property p_oc_clears;
    $rose(pif.oc_set) |=> !pif.status_bit && !pif.power_on;
  endproperty
  a_oc_clears: assert property (p_oc_clears) else $error("Over-current left port on");

  property p_power_join;
    ##1 pif.power_on == $past((pif.host_req || (pif.charge_en && pif.charge_req))
                              && !pif.oc_set);
  endproperty
  a_power_join: assert property (p_power_join) else $error("Port power mismatch");

  property p_charge_gate;
    (!pif.charge_en && !pif.host_req) |=> !pif.power_on;
  endproperty
  a_charge_gate: assert property (p_charge_gate) else $error("Charging not gated");

  c_charge_power: cover property (pif.charge_en && pif.charge_req && !pif.host_req
                                  ##1 pif.power_on);
endmodule

`default_nettype wire

// ==== logic/ppoc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none

module ppoc_regs
  import ppoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register access from the configuration serial slave
  input wire ppoc_addr_t reg_addr,
  input wire logic reg_wr_en,
  input wire ppoc_byte_t reg_wdata,
  input wire logic reg_rd_en,
  output ppoc_byte_t reg_rdata,
  output logic reg_rd_valid,
  // Hub core power requests and charging control
  input wire ppoc_ports_t host_power_req,
  input wire ppoc_ports_t charge_enable,
  input wire ppoc_ports_t charge_power_req,
  // Port power and hub status reporting
  output ppoc_ports_t port_power_on,
  output ppoc_ports_t hub_overcurrent,
  output ppoc_ports_t overcurrent_change
);

  ppoc_ports_t oc_reg;
  ppoc_ports_t oc_next;
  ppoc_byte_t rdata_reg;
  ppoc_byte_t rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  ppoc_ports_t status_vec;
  ppoc_ports_t power_vec;
  ppoc_ports_t rise_vec;
  logic wr_oc;
  logic rd_pp;
  logic rd_oc;

  // ==========================================================
  // Address decode
  assign wr_oc = reg_wr_en && (reg_addr == `PPOC_ADDR_OC_INJECT);
  assign rd_pp = reg_rd_en && (reg_addr == `PPOC_ADDR_PORT_POWER);
  assign rd_oc = reg_rd_en && (reg_addr == `PPOC_ADDR_OC_INJECT);

  // ==========================================================
  // Over-current inject register
  // Bits 3:1 stored; reserved bits dropped and held at zero
  always_comb
  begin
    oc_next = oc_reg;
    if (wr_oc)
    begin
      oc_next = reg_wdata[`PPOC_PORT_HI:`PPOC_PORT_LO];
    end
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      oc_reg <= '0;
    end
    else
    begin
      oc_reg <= oc_next;
    end
  end

  // ==========================================================
  // Read path
  // Read data one cycle after the strobe; unmapped reads zero
  always_comb
  begin
    rdata_next = rdata_reg;
    rd_valid_next = reg_rd_en;
    if (rd_pp)
    begin
      rdata_next = `PPOC_RESET_BYTE;
      rdata_next[`PPOC_PORT_HI:`PPOC_PORT_LO] = status_vec;
    end
    else if (rd_oc)
    begin
      rdata_next = `PPOC_RESET_BYTE;
      rdata_next[`PPOC_PORT_HI:`PPOC_PORT_LO] = oc_reg;
    end
    else if (reg_rd_en)
    begin
      rdata_next = `PPOC_RESET_BYTE;
    end
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_reg <= `PPOC_RESET_BYTE;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ==========================================================
  // Per-port slices
  generate
    for (genvar i = `PPOC_PORT_LO; i <= `PPOC_PORT_HI; i++)
    begin : g_port
      ppoc_port_if pif ();
      assign pif.host_req = host_power_req[i];
      assign pif.charge_en = charge_enable[i];
      assign pif.charge_req = charge_power_req[i];
      assign pif.oc_set = oc_reg[i];
      assign status_vec[i] = pif.status_bit;
      assign power_vec[i] = pif.power_on;
      assign rise_vec[i] = pif.oc_rise;
      ppoc_port_slice u_slice (
        .clk(clk),
        .sys_rst(sys_rst),
        .pif(pif)
      );
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign port_power_on = power_vec;
  assign hub_overcurrent = oc_reg;
  assign overcurrent_change = rise_vec;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_status_read;
    rd_pp |=> reg_rd_valid && reg_rdata[`PPOC_PORT_HI:`PPOC_PORT_LO] == $past(status_vec)
              && reg_rdata[`PPOC_RSVD_HI_MSB:`PPOC_RSVD_HI_LSB] == `PPOC_RSVD_HI_ZERO
              && !reg_rdata[`PPOC_RSVD_LO];
  endproperty
  a_status_read: assert property (p_status_read) else $error("Bad status read");

  property p_status_powered;
    (host_power_req == 3'h7 && oc_reg == 3'h0 ##1 rd_pp)
      |=> reg_rdata[`PPOC_PORT_HI:`PPOC_PORT_LO] == 3'h7;
  endproperty
  a_status_powered: assert property (p_status_powered) else $error("Powered reads zero");

  property p_oc_port3;
    (wr_oc && reg_wdata[`PPOC_PORT_HI]) |=> hub_overcurrent[`PPOC_PORT_HI] ##1
                                             !port_power_on[`PPOC_PORT_HI];
  endproperty
  a_oc_port3: assert property (p_oc_port3) else $error("Port 3 over-current lost");

  property p_oc_low;
    wr_oc |=> hub_overcurrent[`PPOC_PORT_MID:`PPOC_PORT_LO]
              == $past(reg_wdata[`PPOC_PORT_MID:`PPOC_PORT_LO]);
  endproperty
  a_oc_low: assert property (p_oc_low) else $error("Ports 2:1 over-current wrong");

  property p_oc_clear;
    (wr_oc && reg_wdata == `PPOC_RESET_BYTE) |=> hub_overcurrent == 3'h0;
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("Zero did not clear");

  property p_oc_sticky;
    !wr_oc |=> $stable(hub_overcurrent);
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("Over-current changed alone");

  property p_oc_status;
    (wr_oc && reg_wdata[`PPOC_PORT_LO]) |=> ##1 !status_vec[`PPOC_PORT_LO];
  endproperty
  a_oc_status: assert property (p_oc_status) else $error("Status kept on over-current");

  // Every read strobe gets exactly one valid pulse
  property p_rd_answer;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read not answered");

  property p_rd_quiet;
    !reg_rd_en |=> !reg_rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("Valid without read");

  // Over-current readback keeps discarded bits at zero
  property p_oc_read;
    rd_oc |=> reg_rdata == {`PPOC_RSVD_HI_ZERO, $past(oc_reg), 1'b0};
  endproperty
  a_oc_read: assert property (p_oc_read) else $error("Bad over-current read");

  property p_unmapped;
    (reg_rd_en && !rd_pp && !rd_oc) |=> reg_rdata == `PPOC_RESET_BYTE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");

  // Status register ignores writes
  property p_write_ro;
    (reg_wr_en && reg_addr == `PPOC_ADDR_PORT_POWER) |=> $stable(hub_overcurrent);
  endproperty
  a_write_ro: assert property (p_write_ro) else $error("Status write had effect");

  // Change event marks only newly set over-current bits, for one cycle
  property p_change_pulse;
    overcurrent_change == (hub_overcurrent & ~$past(hub_overcurrent));
  endproperty
  a_change_pulse: assert property (p_change_pulse) else $error("Bad change event");

  property p_change_short;
    overcurrent_change != 3'h0 |=> (overcurrent_change & $past(overcurrent_change)) == 3'h0;
  endproperty
  a_change_short: assert property (p_change_short) else $error("Change event too long");

  c_oc_inject: cover property (wr_oc && reg_wdata[`PPOC_PORT_MID] ##1 hub_overcurrent[`PPOC_PORT_MID]
                               ##1 overcurrent_change == 3'h0);
  c_status_read: cover property (rd_pp ##1 reg_rdata != `PPOC_RESET_BYTE);
  c_oc_release: cover property (hub_overcurrent != 3'h0 ##1 hub_overcurrent == 3'h0);
endmodule

`default_nettype wire

// ==== tb/ppoc_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ==========
// Host and charging side, registered like real logic
module ppoc_host_model
  import ppoc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Commands from the bench
  input wire ppoc_ports_t host_cmd,
  input wire ppoc_ports_t en_cmd,
  input wire ppoc_ports_t req_cmd,
  // Levels towards the block
  output ppoc_ports_t host_power_req,
  output ppoc_ports_t charge_enable,
  output ppoc_ports_t charge_power_req
);
  ppoc_ports_t host_next;
  ppoc_ports_t en_next;
  ppoc_ports_t req_next;
  // Everything off while in reset
  always_comb
  begin
    host_next = sys_rst ? 3'h0 : host_cmd;
    en_next = sys_rst ? 3'h0 : en_cmd;
    req_next = sys_rst ? 3'h0 : req_cmd;
  end
  // Output registers
  always_ff @(posedge clk)
  begin
    host_power_req <= host_next;
    charge_enable <= en_next;
    charge_power_req <= req_next;
  end
endmodule

`default_nettype wire

// ==== tb/test_port_power_overcurrent_regs.sv ====
`timescale 1ns/1ns
`default_nettype none

module test_port_power_overcurrent_regs
  import ppoc_pkg::*;
();
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ppoc_addr_t reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  ppoc_byte_t reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  ppoc_ports_t host_cmd = 3'h0;
  ppoc_ports_t en_cmd = 3'h0;
  ppoc_ports_t req_cmd = 3'h0;
  ppoc_byte_t reg_rdata;
  logic reg_rd_valid;
  ppoc_ports_t host_power_req;
  ppoc_ports_t charge_enable;
  ppoc_ports_t charge_power_req;
  ppoc_ports_t port_power_on;
  ppoc_ports_t hub_overcurrent;
  ppoc_ports_t overcurrent_change;
  int failures = 0;
  int samples_checked = 0;

  // ==========
  // Clock, partner and block
  always #4 clk = ~clk;

  ppoc_host_model host_u (.clk(clk), .sys_rst(sys_rst), .host_cmd(host_cmd),
    .en_cmd(en_cmd), .req_cmd(req_cmd), .host_power_req(host_power_req),
    .charge_enable(charge_enable), .charge_power_req(charge_power_req));

  ppoc_regs dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .host_power_req(host_power_req), .charge_enable(charge_enable),
    .charge_power_req(charge_power_req), .port_power_on(port_power_on),
    .hub_overcurrent(hub_overcurrent), .overcurrent_change(overcurrent_change));

  // ==========
  // Tasks
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input ppoc_byte_t got, input ppoc_byte_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Port levels in register byte layout
  task automatic chk_ports(input ppoc_byte_t pw, input ppoc_byte_t oc);
    check({4'h0, port_power_on, 1'b0}, pw);
    check({4'h0, hub_overcurrent, 1'b0}, oc);
  endtask

  task automatic wr(input ppoc_addr_t a, input ppoc_byte_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
  endtask

  // Read with a bounded wait for valid
  task automatic rd(input ppoc_addr_t a, input ppoc_byte_t exp);
    int n;
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    n = 0;
    while (reg_rd_valid !== 1'b1 && n < 4)
    begin
      tick(1);
      n++;
    end
    if (reg_rd_valid !== 1'b1)
    begin
      failures++;
      $display("Error at %0t: read timeout", $time);
      close_out();
    end
    else
    begin
      check(reg_rdata, exp);
      tick(1);
    end
  endtask

  // ==========
  // Main sequence
  initial
  begin
    tick(8);
    sys_rst = 1'b0;
    rd(8'he5, 8'h00);
    rd(8'he6, 8'h00);
    host_cmd = 3'h7;
    tick(2);
    chk_ports(8'h0e, 8'h00);
    rd(8'he5, 8'h0e);
    wr(8'he5, 8'h00);
    rd(8'he5, 8'h0e);
    for (int i = 1; i <= 3; i++)
    begin
      wr(8'he6, 8'h01 << i);
      check({4'h0, overcurrent_change, 1'b0}, 8'h01 << i);
      tick(1);
      check({4'h0, overcurrent_change, 1'b0}, 8'h00);
      chk_ports(8'h0e ^ (8'h01 << i), 8'h01 << i);
      rd(8'he5, 8'h0e ^ (8'h01 << i));
      rd(8'he6, 8'h01 << i);
    end
    wr(8'he6, 8'h0f);
    rd(8'he6, 8'h0e);
    host_cmd = 3'h0;
    en_cmd = 3'h7;
    req_cmd = 3'h7;
    wr(8'he6, 8'h0a);
    tick(2);
    chk_ports(8'h04, 8'h0a);
    rd(8'he5, 8'h00);
    en_cmd = 3'h0;
    tick(2);
    chk_ports(8'h00, 8'h0a);
    wr(8'he6, 8'h00);
    en_cmd = 3'h7;
    tick(2);
    chk_ports(8'h0e, 8'h00);
    rd(8'he5, 8'h00);
    rd(8'h10, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
